//--- hw/branch_unit_regs.svh
// register offsets, field positions, reset values and cycle counts
`ifndef BRANCH_UNIT_REGS_SVH
`define BRANCH_UNIT_REGS_SVH

// ----------------------------------------
// word offsets on the bus (byte addresses)
// ----------------------------------------
`define OFS_INSTR   9'h000
`define OFS_PC      9'h004
`define OFS_STATUS  9'h008
`define OFS_INFO    9'h00c
`define BASE_IO     9'h080
`define BASE_WREG   9'h100

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_PC      16'h0000
`define RST_STATUS  8'h00

// ----------------------------------------
// status_register flag positions
// ----------------------------------------
`define FLG_C       3'd0
`define FLG_Z       3'd1
`define FLG_N       3'd2
`define FLG_V       3'd3
`define FLG_S       3'd4
`define FLG_H       3'd5

// ----------------------------------------
// issue word and info fields
// ----------------------------------------
`define NEXT_TWO_BIT 16
`define INFO_BUSY   0
`define INFO_CYC_LO 1
`define INFO_TAKEN  3
`define INFO_UNSUP  4

// ----------------------------------------
// cycle counts per outcome
// ----------------------------------------
`define CYC_ONE     2'd1
`define CYC_TWO     2'd2
`define CYC_THREE   2'd3

`endif

//--- hw/branch_unit_pkg.sv
// types shared by the branch and skip unit
package branch_unit_pkg;

	// execution sequencer, one-hot
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_EXEC = 2'b10
	} exec_state_t;

	// decoded instruction class
	typedef enum logic [2:0] {
		OP_BRANCH = 3'h0,
		OP_SKIP   = 3'h1,
		OP_SETIO  = 3'h2,
		OP_CLRIO  = 3'h3,
		OP_SHIFT  = 3'h4,
		OP_OTHER  = 3'h5
	} op_class_t;

endpackage : branch_unit_pkg

//--- hw/branch_unit.sv
// conditional branch, io skip, io bit set/clear and shift-left unit
//
// Contract
// - io bit one skips next, pc plus 2/3
// - flag-set branch jumps pc+offset+1 when set
// - flag-clear branch jumps only when flag zero
// - equal on zero one, not-equal on zero
// - carry-set/lower on C one; clear/same-or-higher zero
// - minus on negative one, plus on zero
// - signed ge taken when N xor V zero
// - signed less taken when N xor V one
// - half-carry branches test H set or clear
// - transfer-bit branches test T set or clear
// - overflow branches test V set or clear
// - irq branches test global enable flag
// - set io bit, others kept, two cycles
// - clear io bit, flags kept, two cycles
// - shift left, zero in, update Z C N V
`timescale 1ns/100ps
`include "branch_unit_regs.svh"

module branch_unit (
	input  wire logic        clk_i,    // core clock, 25 MHz
	input  wire logic        rst_i,    // synchronous, active high
	input  wire logic        ce_i,     // low freezes all state
	input  wire logic        cyc_i,    // wishbone cycle
	input  wire logic        stb_i,    // wishbone strobe
	input  wire logic        we_i,     // wishbone write
	input  wire logic [8:0]  adr_i,    // byte address
	input  wire logic [3:0]  sel_i,    // byte enables
	input  wire logic [31:0] dat_i,    // write data
	output logic      [31:0] dat_o,    // read data
	output logic             ack_o,    // one-cycle answer
	output logic      [15:0] pc_o,     // program counter
	output logic      [7:0]  status_o, // status_register
	output branch_unit_pkg::exec_state_t state_o // sequencer
);
	import branch_unit_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic        [15:0] pc_r;         // program counter
	logic        [7:0]  status_r;     // flags I T H S V N Z C
	logic        [7:0]  io_r [32];    // io register space
	logic        [7:0]  wreg_r [32];  // working registers
	logic        [16:0] instr_r;      // last issued word
	exec_state_t        state_r;      // sequencer state
	exec_state_t        state_nxt;
	logic        [1:0]  left_r;       // cycles still to run
	logic        [1:0]  cyc_r;        // cycles of last op
	logic               taken_r;      // last branch/skip taken
	logic               unsup_r;      // last word not ours
	logic               ack_r;        // bus answer
	logic        [31:0] rdat_r;       // registered read data

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	wire         req      = cyc_i & stb_i & ~ack_r & ce_i;
	wire         wr_acc   = req & we_i;
	wire         hit_ins  = adr_i == `OFS_INSTR;
	wire         hit_pc   = adr_i == `OFS_PC;
	wire         hit_st   = adr_i == `OFS_STATUS;
	wire         hit_inf  = adr_i == `OFS_INFO;
	wire  [8:0]  io_base  = `BASE_IO;   // io window base, named so its bits can be selected
	wire  [8:0]  wr_base  = `BASE_WREG; // working register window base
	wire         hit_io   = adr_i[8:7] == io_base[8:7];
	wire         hit_wr   = adr_i[8] == wr_base[8];
	wire  [4:0]  bidx     = adr_i[6:2];
	wire         busy     = state_r == ST_EXEC;
	// an issue needs the low half written and an idle sequencer;
	// a write while busy is answered but dropped
	wire         issue    = wr_acc & hit_ins & (&sel_i[1:0]) & ~busy;

	// ----------------------------------------
	// instruction decode
	// ----------------------------------------
	wire  [15:0] iw       = dat_i[15:0];
	wire         two_next = dat_i[`NEXT_TWO_BIT];
	wire         is_br    = iw[15:11] == 5'b11110;
	wire         br_clr   = iw[10];
	wire  [2:0]  fsel     = iw[2:0];
	wire  [6:0]  koff     = iw[9:3];
	wire         is_skip  = iw[15:8] == 8'h9b;
	wire         is_setio = iw[15:8] == 8'h9a;
	wire         is_clrio = iw[15:8] == 8'h98;
	wire  [4:0]  ioa      = iw[7:3];
	wire  [2:0]  bsel     = iw[2:0];
	wire         is_shift = (iw[15:10] == 6'b000011) & (iw[9] == iw[8])
				& (iw[3:0] == iw[7:4]);
	wire  [4:0]  rd_idx   = iw[8:4];
	op_class_t   op;

	// class select, one hot in practice
	assign op = is_br    ? OP_BRANCH :
		    is_skip  ? OP_SKIP   :
		    is_setio ? OP_SETIO  :
		    is_clrio ? OP_CLRIO  :
		    is_shift ? OP_SHIFT  : OP_OTHER;

	// ----------------------------------------
	// branch condition
	// ----------------------------------------
	// the signed test is formed from N and V here rather than read
	// from the stored S bit, so a stale S cannot steer it
	wire         nxv      = status_r[`FLG_N] ^ status_r[`FLG_V];
	// index 0 C, 1 Z, 2 N, 3 V, 5 H, 6 T, 7 I
	wire         fval     = (fsel == `FLG_S) ? nxv : status_r[fsel];
	// set form takes on one, clear form on zero
	wire         cond     = br_clr ? ~fval : fval;

	// ----------------------------------------
	// targets
	// ----------------------------------------
	// offset sign-extended so backward branches wrap correctly
	wire  [15:0] kext     = {{9{koff[6]}}, koff};
	wire  [15:0] pc_inc   = pc_r + 16'h0001;
	wire  [15:0] tgt      = pc_inc + kext;
	wire  [7:0]  iobyte   = io_r[ioa];
	wire         iobit    = iobyte[bsel];
	wire  [15:0] skp      = pc_r + (two_next ? 16'h0003 : 16'h0002);

	// ----------------------------------------
	// shift left result and flags
	// ----------------------------------------
	wire  [7:0]  rdv      = wreg_r[rd_idx];
	wire  [7:0]  shres    = {rdv[6:0], 1'b0};
	wire         sh_c     = rdv[7];
	wire         sh_n     = shres[7];
	wire         sh_v     = sh_n ^ sh_c;
	wire  [7:0]  sh_flags = {status_r[7:6], rdv[3], sh_n ^ sh_v, sh_v, sh_n,
				 shres == 8'h00, sh_c};

	// ----------------------------------------
	// outcome per class
	// ----------------------------------------
	wire         took     = (is_br & cond) | (is_skip & iobit);
	wire  [15:0] pc_new   = (is_br & cond)    ? tgt :
				(is_skip & iobit) ? skp : pc_inc;
	// one cycle unless taken or an io bit set/clear; skip costs one per skipped word
	wire  [1:0]  ncyc     = (is_br & cond) ? `CYC_TWO :
				(is_skip & iobit) ? (two_next ? `CYC_THREE : `CYC_TWO) :
				(is_setio | is_clrio) ? `CYC_TWO : `CYC_ONE;
	// new io byte, only the addressed bit changes
	wire  [7:0]  bmask    = 8'h01 << bsel;
	wire  [7:0]  io_new   = is_setio ? (iobyte | bmask) : (iobyte & ~bmask);

	// ----------------------------------------
	// byte-lane merge for plain writes
	// ----------------------------------------
	wire  [15:0] pc_wr    = {sel_i[1] ? dat_i[15:8] : pc_r[15:8],
				 sel_i[0] ? dat_i[7:0] : pc_r[7:0]};
	wire  [7:0]  bus_rd   = hit_io ? io_r[bidx] : wreg_r[bidx];

	// read mux, unmapped reads zero
	wire  [31:0] rd_mux   = hit_ins ? {15'h0000, instr_r} :
				hit_pc  ? {16'h0000, pc_r} :
				hit_st  ? {24'h000000, status_r} :
				hit_inf ? {27'h0000000, unsup_r, taken_r, cyc_r, busy} :
				(hit_io | hit_wr) ? {24'h000000, bus_rd} : 32'h00000000;

	// ----------------------------------------
	// sequencer next state
	// ----------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: if (issue && ncyc != `CYC_ONE) state_nxt = ST_EXEC;
			ST_EXEC: if (ce_i && left_r == 2'd1) state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE; // illegal code recovers
		endcase
	end

	// ----------------------------------------
	// bus handshake and read data
	// ----------------------------------------
	// ack drops the cycle after it was given
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_r  <= 1'b0;
			rdat_r <= 32'h00000000;
		end
		else if (ce_i)
		begin
			ack_r  <= cyc_i & stb_i & ~ack_r;
			rdat_r <= rd_mux;
		end
	end

	// ----------------------------------------
	// sequencer and issue record
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_r <= ST_IDLE;
			left_r  <= 2'd0;
			cyc_r   <= 2'd0;
			taken_r <= 1'b0;
			unsup_r <= 1'b0;
			instr_r <= 17'h00000;
		end
		else if (ce_i)
		begin
			state_r <= state_nxt;
			if (issue)
			begin
				left_r  <= ncyc - `CYC_ONE;
				cyc_r   <= ncyc;
				taken_r <= took;
				unsup_r <= op == OP_OTHER;
				instr_r <= dat_i[16:0];
			end
			else if (busy)
				left_r <= left_r - 2'd1;
		end
	end

	// ----------------------------------------
	// pc and flags
	// ----------------------------------------
	// all effects land at the issue edge; the extra cycles only
	// hold off the next issue, matching each op's cycle cost
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pc_r     <= `RST_PC;
			status_r <= `RST_STATUS;
		end
		else if (ce_i)
		begin
			if (issue)
				pc_r <= pc_new;
			else if (wr_acc && hit_pc)
				pc_r <= pc_wr;
			if (issue && is_shift)
				status_r <= sh_flags;
			else if (wr_acc && hit_st && sel_i[0])
				status_r <= dat_i[7:0];
		end
	end

	// ----------------------------------------
	// io and working register storage
	// ----------------------------------------
	// no reset on storage, as in a core's register file
	always_ff @(posedge clk_i)
	begin
		if (ce_i && !rst_i)
		begin
			if (issue && (is_setio || is_clrio))
				io_r[ioa] <= io_new;
			else if (wr_acc && hit_io && sel_i[0])
				io_r[bidx] <= dat_i[7:0];
			if (issue && is_shift)
				wreg_r[rd_idx] <= shres;
			else if (wr_acc && hit_wr && sel_i[0])
				wreg_r[bidx] <= dat_i[7:0];
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign ack_o    = ack_r;
	assign dat_o    = rdat_r;
	assign pc_o     = pc_r;
	assign status_o = status_r;
	assign state_o  = state_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_taken_issue;
		issue && is_br && cond;
	endsequence

	sequence s_two_cycle_op;
		issue && (is_setio || is_clrio) ##1 (busy && ce_i);
	endsequence

	a_branch_target: assert property (s_taken_issue |=> pc_r == $past(tgt))
		else $error("taken branch target wrong");

	a_branch_fallthru: assert property (issue && is_br && !cond |=>
		pc_r == $past(pc_r) + 16'h0001 && !busy)
		else $error("untaken branch did not fall through");

	a_signed_ge: assert property (issue && is_br && br_clr && fsel == `FLG_S
		&& !(status_r[`FLG_N] ^ status_r[`FLG_V]) |=> pc_r == $past(tgt))
		else $error("signed ge not taken");

	a_signed_less: assert property (issue && is_br && !br_clr && fsel == `FLG_S
		&& !(status_r[`FLG_N] ^ status_r[`FLG_V]) |=>
		pc_r == $past(pc_r) + 16'h0001)
		else $error("signed less taken wrongly");

	// target rebuilt from the raw offset bits rather than the shared adder
	a_signed_less_jump: assert property (issue && is_br && !br_clr && fsel == `FLG_S
		&& (status_r[`FLG_N] ^ status_r[`FLG_V]) |=>
		pc_r == $past(pc_r) + 16'h0001 + {{9{$past(koff[6])}}, $past(koff)})
		else $error("signed less not taken");

	a_taken_cycles: assert property (s_taken_issue ##1 (busy && ce_i) |=> !busy)
		else $error("taken branch not two cycles");

	a_skip_pc: assert property (issue && is_skip && iobit |=>
		pc_r == $past(pc_r) + ($past(two_next) ? 16'h0003 : 16'h0002))
		else $error("skip distance wrong");

	a_skip_fallthru: assert property (issue && is_skip && !iobit |=>
		pc_r == $past(pc_r) + 16'h0001 && !busy)
		else $error("untaken skip did not fall through");

	a_io_two_cycle: assert property (s_two_cycle_op |=> !busy)
		else $error("io bit op not two cycles");

	a_io_bit_value: assert property (issue && (is_setio || is_clrio) |=>
		io_r[$past(ioa)] == $past(io_new) && status_r == $past(status_r))
		else $error("io bit op result or flags wrong");

	a_shift_result: assert property (issue && is_shift |=>
		wreg_r[$past(rd_idx)] == {$past(rdv[6:0]), 1'b0}
		&& status_r[`FLG_C] == $past(rdv[7]))
		else $error("shift left result or carry wrong");

	a_shift_flags: assert property (issue && is_shift |=>
		status_r[`FLG_N] == $past(rdv[6])
		&& status_r[`FLG_V] == ($past(rdv[6]) ^ $past(rdv[7]))
		&& status_r[`FLG_Z] == ($past(rdv[6:0]) == 7'h00))
		else $error("shift left flags wrong");

	// modular distance, so a backward jump across address zero still holds
	a_backward_wrap: assert property (issue && is_br && cond && koff[6] |=>
		pc_r == $past(pc_r) + 16'h0001 - (16'h0080 - {9'h000, $past(koff)}))
		else $error("negative offset did not go back");

	// a low enable must hold the counter, the sequencer and the bus answer
	a_freeze_hold: assert property (!ce_i |=> pc_r == $past(pc_r)
		&& state_r == $past(state_r) && ack_r == $past(ack_r))
		else $error("state moved while enable low");

endmodule : branch_unit

//--- testbench/prog_mem.sv
// program memory model that hands instruction words to the bench
`timescale 1ns/100ps

module prog_mem (
	input  wire logic [15:0] addr_i, // word address, follows the program counter
	output logic      [16:0] word_o  // bit 16 marks a two-word successor
);
	// ----------------------------------------
	// fixed program image
	// ----------------------------------------
	// combinational, so a fetch reflects the counter as soon as it settles
	always_comb
	begin
		case (addr_i)
			16'h0000: word_o = 17'h09a29; // set io 5 bit 1
			16'h0001: word_o = 17'h0982f; // clear io 5 bit 7
			16'h0002: word_o = 17'h00c33; // shift left work reg 3
			16'h0003: word_o = 17'h19b28; // skip on io 5 bit 0, next is two words
			16'h0006: word_o = 17'h09b2b; // skip on io 5 bit 3
			16'h0007: word_o = 17'h09b2a; // skip on io 5 bit 2, next is one word
			default:  word_o = 17'h1ffff; // unprogrammed words read as all ones
		endcase
	end
endmodule : prog_mem

//--- testbench/tb.sv
// self-checking bench for the branch and skip unit
`timescale 1ns/100ps
`include "branch_unit_regs.svh"

module tb;
	import branch_unit_pkg::*;
	logic        clk_i, rst_i, ce_i, cyc_i, stb_i, we_i; // bench-driven controls
	logic [8:0]  adr_i;       // byte address
	logic [3:0]  sel_i;       // byte lanes
	logic [31:0] dat_i, q;    // write data, last read data
	wire  [31:0] dat_o;       // read data
	wire         ack_o;       // bus answer
	wire  [15:0] pc_o;        // program counter
	wire  [7:0]  status_o;    // flags
	exec_state_t state_o;     // sequencer
	exec_state_t last_st;     // sequencer seen at the ack edge
	wire  [16:0] prog_word;   // word fetched at pc_o
	int          bad_count, total_checks;

	branch_unit u_branch_unit (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .pc_o(pc_o), .status_o(status_o), .state_o(state_o));
	prog_mem u_prog_mem (.addr_i(pc_o), .word_o(prog_word));

	// ----------------------------------------
	// clock, verdict, compares
	// ----------------------------------------
	always #20 clk_i = ~clk_i;

	task automatic summarize();
		if (bad_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_st(input exec_state_t got, input exec_state_t exp);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_st

	// ----------------------------------------
	// bus cycle and issue helpers
	// ----------------------------------------
	// one classic cycle; the sequencer is caught at the ack edge, where extra cycles show
	task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'b1 && n < 50);
		q = dat_o;
		last_st = state_o;
		if (n >= 50)
		begin
			bad_count++;
			summarize();
		end
		else
		begin
			cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
		end
	endtask : wb

	// issue a word, then wait until extra cycles run out so the next issue is not dropped
	task automatic issue(input logic [16:0] w);
		int n;
		wb(1'b1, `OFS_INSTR, {15'h0, w});
		n = 0;
		while (state_o !== ST_IDLE && n < 10)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 10)
		begin
			bad_count++;
			summarize();
		end
	endtask : issue

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic test_reset();
		@(posedge clk_i);
		chk({16'h0, pc_o}, 32'h0);
		chk({24'h0, status_o}, 32'h0);
		chk_st(state_o, ST_IDLE);
	endtask : test_reset

	// every flag index, both senses, both flag values, forward and backward offsets
	task automatic test_branches();
		logic [7:0]  sv;
		logic [6:0]  k;
		logic        tk;
		logic [15:0] ep;
		for (int s = 0; s < 8; s++)
			for (int c = 0; c < 2; c++)
				for (int f = 0; f < 2; f++)
				begin
					// index 4 pairs N with V, and stored S opposes the combined value
					sv = (s == 4) ? (f ? 8'h04 : 8'h1c) : (f ? 8'h01 << s : ~(8'h01 << s));
					k = s[0] ? 7'h7d : 7'h05;
					tk = c ? !f : f;
					ep = tk ? 16'h0101 + {{9{k[6]}}, k} : 16'h0101;
					wb(1'b1, `OFS_STATUS, {24'h0, sv});
					wb(1'b1, `OFS_PC, 32'h0100);
					issue({1'b0, 5'b11110, c[0], k, s[2:0]});
					chk_st(last_st, tk ? ST_EXEC : ST_IDLE);
					chk({16'h0, pc_o}, {16'h0, ep});
					chk({24'h0, status_o}, {24'h0, sv});
					wb(1'b0, `OFS_INFO, 32'h0);
					chk(q & 32'h1f, {28'h0, tk, tk ? 2'd2 : 2'd1, 1'b0});
				end
	endtask : test_branches

	// runs the stored program: io bit set and clear, shift left, skips, an unsupported word
	task automatic test_program();
		logic [15:0] pcs [7] = '{16'h1, 16'h2, 16'h3, 16'h6, 16'h7, 16'h9, 16'ha};
		logic [7:0]  sts [7] = '{8'hc0, 8'hc0, 8'hf9, 8'hf9, 8'hf9, 8'hf9, 8'hf9};
		logic [1:0]  cys [7] = '{2'd2, 2'd2, 2'd1, 2'd3, 2'd1, 2'd2, 2'd1};
		logic        tks [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
		logic        uns [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
		wb(1'b1, 9'h094, 32'ha5);
		wb(1'b1, 9'h10c, 32'h88);
		wb(1'b1, `OFS_STATUS, 32'hc0);
		wb(1'b1, `OFS_PC, 32'h0);
		for (int i = 0; i < 7; i++)
		begin
			issue(prog_word);
			chk_st(last_st, cys[i] > 2'd1 ? ST_EXEC : ST_IDLE);
			chk({16'h0, pc_o}, {16'h0, pcs[i]});
			chk({24'h0, status_o}, {24'h0, sts[i]});
			wb(1'b0, `OFS_INFO, 32'h0);
			chk(q & 32'h1f, {27'h0, uns[i], tks[i], cys[i], 1'b0});
		end
		wb(1'b0, 9'h094, 32'h0);
		chk(q & 32'hff, 32'h27);
		wb(1'b0, 9'h10c, 32'h0);
		chk(q & 32'hff, 32'h10);
		wb(1'b0, 9'h010, 32'h0);
		chk(q, 32'h0);
	endtask : test_program

	// a write presented while the enable is low must wait for it, then land
	task automatic test_freeze();
		fork
			wb(1'b1, `OFS_PC, 32'h0234);
			begin
				@(posedge clk_i);
				ce_i <= 1'b0;
				repeat (3) @(posedge clk_i);
				chk({31'h0, ack_o}, 32'h0);
				chk({16'h0, pc_o}, 32'h000a);
				ce_i <= 1'b1;
			end
		join
		chk({16'h0, pc_o}, 32'h0234);
	endtask : test_freeze

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		bad_count = 0; total_checks = 0;
		clk_i = 1'b0; rst_i = 1'b1; ce_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0;
		we_i = 1'b0; adr_i = 9'h000; sel_i = 4'hf; dat_i = 32'h0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		test_reset();
		test_branches();
		test_program();
		test_freeze();
		summarize();
	end
endmodule : tb
